/* File: verif/gfg_board.sv */
// Board model: outside sources on the port pads, resolved against the block's drive
`timescale 1ns/1ns
`default_nettype none
module gfg_board (
    // Block drive
    input wire logic [7:0] pf_out,
    input wire logic [7:0] pf_oe,
    input wire logic [4:0] pg_out,
    input wire logic [4:0] pg_oe,
    // Outside source levels, always driven, so no pad ever floats
    input wire logic [7:0] ext_f,
    input wire logic [4:0] ext_g,
    // Resolved pad levels
    output logic [7:0] pf_in,
    output logic [4:0] pg_in
);
    // Block wins where it drives; the outside source shows elsewhere
    assign pf_in = (pf_oe & pf_out) | (~pf_oe & ext_f);
    assign pg_in = (pg_oe & pg_out) | (~pg_oe & ext_g);
endmodule
`default_nettype wire

/* File: verif/gfg_ports_tb.sv */
// Self-checking bench for the two-port pin block over APB
`timescale 1ns/1ns
`default_nettype none
`include "gfg_map.svh"
module gfg_ports_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, strap, mclr_in;
    logic tx_en, tx, sd_en, sd, rx_in;
    logic rtcc_en, rtcc, tmr_clk, tmr_gate, ss_in, ck_in;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [7:0] pf_in, pf_out, pf_oe, ext_f;
    logic [4:0] pg_in, pg_out, pg_oe, ext_g;
    logic [2:0] cmp_out, ccp_act, ccp_out, ccp_cap;
    logic serr;
    int n_errors = 0;
    int checked = 0;

    gfg_ports DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pf_in(pf_in), .pf_out(pf_out), .pf_oe(pf_oe), .pg_in(pg_in), .pg_out(pg_out), .pg_oe(pg_oe),
        .mclr_pin_in(mclr_in), .master_clear_pin_enable(strap), .cmp_out(cmp_out), .ccp_act(ccp_act),
        .ccp_out(ccp_out), .ccp_cap_in(ccp_cap), .serial_two_transmit_en(tx_en), .serial_two_transmit(tx),
        .serial_two_sync_data_en(sd_en), .serial_two_sync_data(sd), .serial_two_rx_in(rx_in),
        .serial_two_clk_in(ck_in), .rtcc_out_en(rtcc_en), .rtcc_out(rtcc), .timer_clk_in(tmr_clk),
        .timer_gate_in(tmr_gate), .slave_select_in(ss_in));

    gfg_board board (.pf_out(pf_out), .pf_oe(pf_oe), .pg_out(pg_out), .pg_oe(pg_oe),
        .ext_f(ext_f), .ext_g(ext_g), .pf_in(pf_in), .pg_in(pg_in));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, 100 MHz
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Comparison with case equality, so an unknown never passes
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer; the request stands until pready is seen high at an edge
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        chk(nm, e, rdat);
    endtask

    // Pads are combinational: what the last edge launched has settled by the next edge
    // The caller reads the pad only after this returns, so no stale value is compared
    task automatic settle;
        @(posedge pclk);
    endtask

    // Single closing point for the run
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog, far beyond the roughly 150 cycles the tests need
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        finish_test;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, strap, mclr_in, tx_en, tx, sd_en, sd, rtcc_en, rtcc} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cmp_out = 3'h0;
        ccp_act = 3'h0;
        ccp_out = 3'h0;
        ext_f = 8'hFF;
        ext_g = 5'h1F;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd("f dir reset", `GFG_OFS_PF_DIR, 32'hFE);
        rd("g dir reset", `GFG_OFS_PG_DIR, 32'h1F);
        rd("an lo reset", `GFG_OFS_AN_LO, 32'hFF);
        rd("an mid reset", `GFG_OFS_AN_MID, 32'hFF);
        rd("an hi reset", `GFG_OFS_AN_HI, 32'hFF);
        rd("f pin reset", `GFG_OFS_PF_PIN, 32'h0);
        settle;
        chk("f oe reset", 32'h0, 32'(pf_oe));
        xfer(8'h40, 1'b0, 32'h0);
        chk("unmapped err", 32'h1, 32'(serr));
        chk("unmapped data", 32'h0, rdat);
        // Latch and direction: unimplemented bit 0, analog leaves output path alone
        wr(`GFG_OFS_PF_LAT, 32'hFF);
        rd("f lat bit0", `GFG_OFS_PF_LAT, 32'hFE);
        wr(`GFG_OFS_PF_DIR, 32'h0);
        settle;
        chk("f oe out", 32'hFE, 32'(pf_oe));
        chk("f out analog", 32'hFE, 32'(pf_out));
        wr(`GFG_OFS_PF_PIN, 32'h54);
        rd("f lat via pin", `GFG_OFS_PF_LAT, 32'h54);
        settle;
        chk("f out latch", 32'h54, 32'(pf_out));
        // Digital input only after analog selects are cleared
        wr(`GFG_OFS_PF_DIR, 32'hFE);
        ext_f <= 8'hAA;
        rd("f pin analog", `GFG_OFS_PF_PIN, 32'h0);
        wr(`GFG_OFS_AN_LO, 32'h0);
        wr(`GFG_OFS_AN_MID, 32'h0);
        rd("f pin digital", `GFG_OFS_PF_PIN, 32'hAA);
        chk("slave select", 32'h1, 32'(ss_in));
        // Segments on pins 1 and 3 own them
        wr(`GFG_OFS_SEG2, 32'h28);
        rd("f pin seg", `GFG_OFS_PF_PIN, 32'hA0);
        wr(`GFG_OFS_PF_DIR, 32'h0);
        settle;
        chk("f oe seg", 32'hF4, 32'(pf_oe));
        wr(`GFG_OFS_SEG2, 32'h0);
        // Reference output on pin 5 blocks both directions
        wr(`GFG_OFS_VREF, 32'hC0);
        settle;
        chk("f oe vref", 32'hDE, 32'(pf_oe));
        wr(`GFG_OFS_PF_DIR, 32'hFE);
        rd("f pin vref", `GFG_OFS_PF_PIN, 32'h8A);
        wr(`GFG_OFS_VREF, 32'h0);
        // Comparator outputs over the latch on pins 2 and 1
        wr(`GFG_OFS_PF_DIR, 32'h0);
        wr(`GFG_OFS_PF_LAT, 32'h0);
        wr(`GFG_OFS_CMP_CTL, 32'h33);
        cmp_out <= 3'h1;
        settle;
        chk("cmp one out", 32'h04, 32'(pf_out));
        cmp_out <= 3'h2;
        settle;
        chk("cmp two out", 32'h02, 32'(pf_out));
        wr(`GFG_OFS_CMP_STAT, 32'hFF);
        rd("cmp status", `GFG_OFS_CMP_STAT, 32'h40);
        wr(`GFG_OFS_CMP_CTL, 32'h0);
        // Second port: master-clear bit, analog default, unimplemented bits
        mclr_in <= 1'b1;
        rd("g pin mclr", `GFG_OFS_PG_PIN, 32'h21);
        strap <= 1'b1;
        rd("g pin no mclr", `GFG_OFS_PG_PIN, 32'h01);
        wr(`GFG_OFS_AN_HI, 32'h0);
        rd("g pin digital", `GFG_OFS_PG_PIN, 32'h1F);
        wr(`GFG_OFS_PG_DIR, 32'hFF);
        rd("g dir upper", `GFG_OFS_PG_DIR, 32'h1F);
        // Capture/compare on pin 3: drives with direction 0, captures with 1
        wr(`GFG_OFS_PG_LAT, 32'h0);
        wr(`GFG_OFS_PG_DIR, 32'h0);
        ccp_act <= 3'h2;
        ccp_out <= 3'h2;
        settle;
        chk("ccp drive", 32'h08, {27'h0, pg_out});
        // Open drain on pin 0 only: a high compare output releases that pad
        wr(`GFG_OFS_OD2, 32'h01);
        ccp_act <= 3'h3;
        ccp_out <= 3'h3;
        settle;
        chk("ccp od oe", 32'h1E, {27'h0, pg_oe});
        wr(`GFG_OFS_PG_DIR, 32'h1F);
        settle;
        chk("ccp capture oe", 32'h0, {27'h0, pg_oe});
        chk("ccp capture in", 32'h07, {29'h0, ccp_cap});
        ccp_act <= 3'h0;
        // Serial transmit forces pin 1 out; direction register keeps its value
        tx_en <= 1'b1;
        tx <= 1'b1;
        settle;
        chk("tx oe", 32'h02, {27'h0, pg_oe});
        chk("tx out", 32'h02, {27'h0, pg_out});
        rd("g dir kept", `GFG_OFS_PG_DIR, 32'h1F);
        wr(`GFG_OFS_OD1, 32'h01);
        settle;
        chk("od high oe", 32'h0, {27'h0, pg_oe});
        tx <= 1'b0;
        settle;
        chk("od low oe", 32'h02, {27'h0, pg_oe});
        chk("od low out", 32'h0, {27'h0, pg_out});
        tx_en <= 1'b0;
        // Sync receive on pin 2 with its direction set to input
        ext_g <= 5'h1B;
        settle;
        chk("sync rx", 32'h0, {31'h0, rx_in});
        chk("serial clk in", 32'h1, {31'h0, ck_in});
        // Sync data output takes pin 2; open drain drives a low
        sd_en <= 1'b1;
        sd <= 1'b0;
        settle;
        chk("sync data oe", 32'h04, {27'h0, pg_oe});
        sd_en <= 1'b0;
        // Clock/calendar output forces pin 4 out; timer inputs see the driven level
        ext_g <= 5'h0B;
        rtcc_en <= 1'b1;
        rtcc <= 1'b1;
        settle;
        chk("rtcc oe", 32'h10, {27'h0, pg_oe});
        chk("timer clk", 32'h1, {31'h0, tmr_clk});
        chk("timer gate", 32'h1, {31'h0, tmr_gate});
        rtcc_en <= 1'b0;
        finish_test;
    end
endmodule
`default_nettype wire

/* File: verilog/gfg_apb_if.sv */
// APB decode for the pin block: zero wait states, error on unmapped words
`timescale 1ns/1ns
`default_nettype none
`include "gfg_map.svh"
module gfg_apb_if #(
    parameter int ADDR_W = 8
) (
    // APB request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    // APB answer
    output logic pready,
    output logic pslverr,
    // Decoded access
    output logic wr_stb,
    output logic rd_setup,
    output logic [7:0] ofs
);
    // Known word: aligned, at or below the last offset, upper bits zero
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        return (a >> 8) == '0 && a[1:0] == 2'h0 && a[7:0] <= `GFG_OFS_LAST;
    endfunction

    if (ADDR_W < 8) begin : g_chk
        $error("gfg_apb_if: ADDR_W must be at least 8");
    end

    // Access phase always completes at once
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_hit(paddr);
    assign wr_stb = psel & penable & pwrite & addr_hit(paddr);
    assign rd_setup = psel & ~penable & ~pwrite;
    assign ofs = paddr[7:0];
endmodule
`default_nettype wire

/* File: verilog/gfg_map.svh */
// Register offsets, reset values and field layouts of the two-port pin block
`ifndef GFG_MAP_SVH
`define GFG_MAP_SVH

// Byte offsets, one aligned 32-bit word each
`define GFG_OFS_PF_PIN 8'h00
`define GFG_OFS_PF_LAT 8'h04
`define GFG_OFS_PF_DIR 8'h08
`define GFG_OFS_PG_PIN 8'h0C
`define GFG_OFS_PG_LAT 8'h10
`define GFG_OFS_PG_DIR 8'h14
`define GFG_OFS_AN_LO 8'h18
`define GFG_OFS_AN_MID 8'h1C
`define GFG_OFS_AN_HI 8'h20
`define GFG_OFS_CMP_CTL 8'h24
`define GFG_OFS_CMP_STAT 8'h28
`define GFG_OFS_VREF 8'h2C
`define GFG_OFS_SEG2 8'h30
`define GFG_OFS_SEG3 8'h34
`define GFG_OFS_OD1 8'h38
`define GFG_OFS_OD2 8'h3C
`define GFG_OFS_LAST 8'h3C

// Implemented bits and reset values
`define GFG_PF_MASK 8'hFE
`define GFG_PG_MASK 8'h1F
`define GFG_RST_DIR_F 8'hFE
`define GFG_RST_DIR_G 8'h1F
`define GFG_RST_LAT 8'h00
`define GFG_RST_ANA 8'hFF
`define GFG_RST_ZERO 8'h00

// Control field positions
`define GFG_CMC_C1_ON 0
`define GFG_CMC_C2_ON 1
`define GFG_CMC_C3_ON 2
`define GFG_CMC_C1_OE 4
`define GFG_CMC_C2_OE 5
`define GFG_CMC_C3_OE 6
`define GFG_VREF_EN 7
`define GFG_VREF_OE 6
`define GFG_OD1_SER2 0
`define GFG_CMP_STAT_LSB 5

// Per-pin field layouts, first port bit 7 down to bit 0, second port bit 4 down to bit 0
`define GFG_F_SEG(s2, s3) {s3[1], s3[0], s2[7:3], 1'b0}
`define GFG_F_ANA(lo, mid) {lo[5], mid[3:0], lo[7:6], 1'b0}
`define GFG_G_SEG(s3) {s3[2], 4'h0}
`define GFG_G_ANA(hi) {hi[0], hi[1], hi[2], hi[3], 1'b0}
`define GFG_G_OD(o1, o2) {o2[2], o2[1], o1[0], o1[0], o2[0]}

`endif

/* File: verilog/gfg_pin_cell.sv */
// One pin: arbitration between segment drive, analog use, peripherals and port data
`timescale 1ns/1ns
`default_nettype none
module gfg_pin_cell (
    // Pad side
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe,
    // Port registers
    input wire logic lat,
    input wire logic dir,
    // Ownership controls
    input wire logic seg,
    input wire logic ana,
    input wire logic blk,
    // Peripheral output
    input wire logic ovr,
    input wire logic frc,
    input wire logic pval,
    input wire logic od,
    // Digital input seen by port read and peripherals
    output logic din
);
    logic own;
    logic per;
    logic val;

    // Segment or reference output takes the pin from everything else
    assign own = ~seg & ~blk;
    // Peripheral output: forced regardless of direction, or override when direction is output
    assign per = frc | (ovr & ~dir);
    assign val = per ? pval : lat;
    // Open drain only releases the pad for a high; it never drives one
    assign pad_oe = own & (per | ~dir) & ~(per & od & val);
    assign pad_out = own & val & ~(per & od);
    // Analog selection blanks digital input only; output path is untouched
    assign din = own & ~ana & pad_in;
endmodule
`default_nettype wire

/* File: verilog/gfg_pkg.sv */
// Types shared by the two-port pin block
`default_nettype none
package gfg_pkg;
    // Every software-visible state bit of the block, registered as one word
    typedef struct packed {
        logic [7:0] f_lat;
        logic [7:0] f_dir;
        logic [7:0] g_lat;
        logic [7:0] g_dir;
        logic [7:0] an_lo;
        logic [7:0] an_mid;
        logic [7:0] an_hi;
        logic [7:0] cmp_ctl;
        logic [7:0] vref_ctl;
        logic [7:0] seg2;
        logic [7:0] seg3;
        logic [7:0] od1;
        logic [7:0] od2;
        logic [31:0] rdata;
    } gfg_state_t;
endpackage
`default_nettype wire

/* File: verilog/gfg_ports.sv */
// Two general-purpose ports with peripheral pin arbitration, registers on APB
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "gfg_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// - First port has pins 7..1; bit 0 of its registers reads zero.
// - Direction bit 0 drives the latch out; direction bit 1 makes an input.
// - After reset first-port pins are analog and read as zero.
// - An enabled segment owns its pin and blocks every other function.
// - Analog selection disables digital input; output latch path stays.
// - Enabled comparator 1 and 2 outputs override latch on pins 2 and 1.
// - Reference output on pin 5 disables its digital input and output.
// - Second port has pins 4..0; upper direction bits read zero.
// - Second port bit 5 reads master-clear pin when that function is off.
// - Peripherals may force a pin to output or input regardless of direction; here they only force output, and inputs follow the direction bit.
// - Peripheral overrides never change the stored direction bits.
// - Open drain for capture/compare and serial pins is set per function.
// - Active capture/compare drives when direction 0, captures when direction 1.
// - Second serial port transmit or sync data output overrides the latch.
// - Second-port analog channels default to analog after reset.
module gfg_ports #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // First port pads, bit 0 unused
    input wire logic [7:0] pf_in,
    output logic [7:0] pf_out,
    output logic [7:0] pf_oe,
    // Second port pads
    input wire logic [4:0] pg_in,
    output logic [4:0] pg_out,
    output logic [4:0] pg_oe,
    // Master-clear pin and its configuration strap
    input wire logic mclr_pin_in,
    input wire logic master_clear_pin_enable,
    // Comparator outputs, bit 0 is comparator one
    input wire logic [2:0] cmp_out,
    // Capture/compare units on second-port pins 0, 3, 4
    input wire logic [2:0] ccp_act,
    input wire logic [2:0] ccp_out,
    output logic [2:0] ccp_cap_in,
    // Second serial port
    input wire logic serial_two_transmit_en,
    input wire logic serial_two_transmit,
    input wire logic serial_two_sync_data_en,
    input wire logic serial_two_sync_data,
    output logic serial_two_rx_in,
    output logic serial_two_clk_in,
    // Clock/calendar output and timer inputs on second-port pin 4
    input wire logic rtcc_out_en,
    input wire logic rtcc_out,
    output logic timer_clk_in,
    output logic timer_gate_in,
    // Slave select input on first-port pin 7
    output logic slave_select_in
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic wr_stb;
    logic rd_setup;
    logic [7:0] ofs;

    gfg_apb_if #(
        .ADDR_W(ADDR_W)
    ) u_apb (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pready(pready),
        .pslverr(pslverr),
        .wr_stb(wr_stb),
        .rd_setup(rd_setup),
        .ofs(ofs)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Per-pin control vectors

    gfg_pkg::gfg_state_t r_reg;
    gfg_pkg::gfg_state_t r_next;
    logic [7:0] f_seg, f_ana, f_blk, f_cin, f_ovr, f_pval, f_din;
    logic [4:0] g_seg, g_ana, g_cin, g_ovr, g_frc, g_pval, g_od, g_din;
    logic c1_on, c2_on, c3_on;
    logic vref_drive;
    logic mclr_rd;

    assign c1_on = r_reg.cmp_ctl[`GFG_CMC_C1_ON];
    assign c2_on = r_reg.cmp_ctl[`GFG_CMC_C2_ON];
    assign c3_on = r_reg.cmp_ctl[`GFG_CMC_C3_ON];
    // Reference only reaches the pin when both enable and output enable are set
    assign vref_drive = r_reg.vref_ctl[`GFG_VREF_EN] & r_reg.vref_ctl[`GFG_VREF_OE];

    // First port: segments, analog selects, reference block
    assign f_seg = `GFG_F_SEG(r_reg.seg2, r_reg.seg3);
    assign f_ana = `GFG_F_ANA(r_reg.an_lo, r_reg.an_mid);
    assign f_blk = {2'h0, vref_drive, 5'h00};
    // A running comparator holds its input pins analog, so digital reads stay zero
    assign f_cin = {1'b0, c1_on, c1_on, c2_on, c2_on, 3'h0};
    // Comparator outputs: two on pin 1, one on pin 2
    assign f_ovr = {5'h00, c1_on & r_reg.cmp_ctl[`GFG_CMC_C1_OE],
                    c2_on & r_reg.cmp_ctl[`GFG_CMC_C2_OE], 1'b0};
    assign f_pval = {5'h00, cmp_out[0], cmp_out[1], 1'b0};

    // Second port: segment on pin 4, analog channels on pins 4..1
    assign g_seg = `GFG_G_SEG(r_reg.seg3);
    assign g_ana = `GFG_G_ANA(r_reg.an_hi);
    assign g_cin = {c3_on, c3_on, c3_on, 2'h0};
    // Capture/compare overrides only while the pin is an output
    assign g_ovr = {ccp_act[2], ccp_act[1], 2'h0, ccp_act[0]};
    // Serial outputs and clock/calendar output ignore the direction bit
    assign g_frc = {rtcc_out_en, 1'b0, serial_two_sync_data_en,
                    serial_two_transmit_en | (c3_on & r_reg.cmp_ctl[`GFG_CMC_C3_OE]), 1'b0};
    // Transmit wins over comparator three on pin 1
    assign g_pval = {ccp_act[2] & ~rtcc_out_en ? ccp_out[2] : rtcc_out, ccp_out[1], serial_two_sync_data,
                     serial_two_transmit_en ? serial_two_transmit : cmp_out[2], ccp_out[0]};
    assign g_od = `GFG_G_OD(r_reg.od1, r_reg.od2);

    ////////////////////////////////////////////////////////////////////////////
    // Pin cells

    // First port, pins 7..1; pad 0 is never driven
    for (genvar i = 1; i < 8; i++) begin : g_pf
        gfg_pin_cell u_cell (
            .pad_in(pf_in[i]),
            .pad_out(pf_out[i]),
            .pad_oe(pf_oe[i]),
            .lat(r_reg.f_lat[i]),
            .dir(r_reg.f_dir[i]),
            .seg(f_seg[i]),
            .ana(f_ana[i] | f_cin[i]),
            .blk(f_blk[i]),
            .ovr(f_ovr[i]),
            .frc(1'b0),
            .pval(f_pval[i]),
            .od(1'b0),
            .din(f_din[i])
        );
    end
    assign pf_out[0] = 1'b0;
    assign pf_oe[0] = 1'b0;
    assign f_din[0] = 1'b0;

    // Second port, pins 4..0
    for (genvar i = 0; i < 5; i++) begin : g_pg
        gfg_pin_cell u_cell (
            .pad_in(pg_in[i]),
            .pad_out(pg_out[i]),
            .pad_oe(pg_oe[i]),
            .lat(r_reg.g_lat[i]),
            .dir(r_reg.g_dir[i]),
            .seg(g_seg[i]),
            .ana(g_ana[i] | g_cin[i]),
            .blk(1'b0),
            .ovr(g_ovr[i]),
            .frc(g_frc[i]),
            .pval(g_pval[i]),
            .od(g_od[i]),
            .din(g_din[i])
        );
    end

    // Peripheral inputs share the digital input path of their pin
    assign ccp_cap_in = {g_din[4], g_din[3], g_din[0]};
    // Sync reception relies on software leaving pin 2 an input
    assign serial_two_rx_in = g_din[2];
    assign serial_two_clk_in = g_din[1];
    assign timer_clk_in = g_din[4];
    assign timer_gate_in = g_din[4];
    assign slave_select_in = f_din[7];
    // Master-clear pin only reads as port data while its reset role is off
    assign mclr_rd = ~master_clear_pin_enable & mclr_pin_in;

    ////////////////////////////////////////////////////////////////////////////
    // Register next state

    logic [7:0] rd_byte;

    always_comb begin
        r_next = r_reg;
        // Read data for the word addressed in the setup phase
        case (ofs)
            `GFG_OFS_PF_PIN: rd_byte = f_din & `GFG_PF_MASK;
            `GFG_OFS_PF_LAT: rd_byte = r_reg.f_lat;
            `GFG_OFS_PF_DIR: rd_byte = r_reg.f_dir;
            `GFG_OFS_PG_PIN: rd_byte = {2'h0, mclr_rd, g_din};
            `GFG_OFS_PG_LAT: rd_byte = r_reg.g_lat;
            `GFG_OFS_PG_DIR: rd_byte = r_reg.g_dir;
            `GFG_OFS_AN_LO: rd_byte = r_reg.an_lo;
            `GFG_OFS_AN_MID: rd_byte = r_reg.an_mid;
            `GFG_OFS_AN_HI: rd_byte = r_reg.an_hi;
            `GFG_OFS_CMP_CTL: rd_byte = r_reg.cmp_ctl;
            `GFG_OFS_CMP_STAT: rd_byte = {cmp_out, 5'h00};
            `GFG_OFS_VREF: rd_byte = r_reg.vref_ctl;
            `GFG_OFS_SEG2: rd_byte = r_reg.seg2;
            `GFG_OFS_SEG3: rd_byte = r_reg.seg3;
            `GFG_OFS_OD1: rd_byte = r_reg.od1;
            `GFG_OFS_OD2: rd_byte = r_reg.od2;
            default: rd_byte = 8'h00;
        endcase
        // Capture at setup so prdata comes straight from a flop in the access phase
        if (rd_setup) begin
            r_next.rdata = {24'h000000, rd_byte};
        end
        // Writes land at the access edge; unimplemented bits of the port latch and direction registers are cut away
        if (wr_stb) begin
            case (ofs)
                `GFG_OFS_PF_PIN, `GFG_OFS_PF_LAT: r_next.f_lat = pwdata[7:0] & `GFG_PF_MASK;
                `GFG_OFS_PF_DIR: r_next.f_dir = pwdata[7:0] & `GFG_PF_MASK;
                `GFG_OFS_PG_PIN, `GFG_OFS_PG_LAT: r_next.g_lat = pwdata[7:0] & `GFG_PG_MASK;
                `GFG_OFS_PG_DIR: r_next.g_dir = pwdata[7:0] & `GFG_PG_MASK;
                `GFG_OFS_AN_LO: r_next.an_lo = pwdata[7:0];
                `GFG_OFS_AN_MID: r_next.an_mid = pwdata[7:0];
                `GFG_OFS_AN_HI: r_next.an_hi = pwdata[7:0];
                `GFG_OFS_CMP_CTL: r_next.cmp_ctl = pwdata[7:0];
                `GFG_OFS_VREF: r_next.vref_ctl = pwdata[7:0];
                `GFG_OFS_SEG2: r_next.seg2 = pwdata[7:0];
                `GFG_OFS_SEG3: r_next.seg3 = pwdata[7:0];
                `GFG_OFS_OD1: r_next.od1 = pwdata[7:0];
                `GFG_OFS_OD2: r_next.od2 = pwdata[7:0];
                default: r_next.rdata = r_reg.rdata;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    // Pins come up as analog inputs, second-port pin 0 as a digital input; latches cleared, direction all inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg.f_lat <= `GFG_RST_LAT;
            r_reg.f_dir <= `GFG_RST_DIR_F;
            r_reg.g_lat <= `GFG_RST_LAT;
            r_reg.g_dir <= `GFG_RST_DIR_G;
            r_reg.an_lo <= `GFG_RST_ANA;
            r_reg.an_mid <= `GFG_RST_ANA;
            r_reg.an_hi <= `GFG_RST_ANA;
            r_reg.cmp_ctl <= `GFG_RST_ZERO;
            r_reg.vref_ctl <= `GFG_RST_ZERO;
            r_reg.seg2 <= `GFG_RST_ZERO;
            r_reg.seg3 <= `GFG_RST_ZERO;
            r_reg.od1 <= `GFG_RST_ZERO;
            r_reg.od2 <= `GFG_RST_ZERO;
            r_reg.rdata <= 32'h00000000;
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata = r_reg.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_f_bit_zero: assert property (!pf_oe[0] && r_reg.f_lat[0] == 1'b0 && r_reg.f_dir[0] == 1'b0)
        else $error("first port bit 0 not inert");

    a_dir_out_drive: assert property (
        !r_reg.f_dir[7] && !f_seg[7] |-> pf_oe[7] && pf_out[7] == r_reg.f_lat[7])
        else $error("output pin 7 not driving latch");

    a_analog_read_zero: assert property (
        rd_setup && ofs == `GFG_OFS_PF_PIN && (f_ana | f_seg) == `GFG_PF_MASK |=> prdata == 32'h00000000)
        else $error("analog pins read nonzero");

    a_seg_owns_pin: assert property (f_seg[3] |-> !pf_oe[3] && !f_din[3])
        else $error("segment pin still used by port");

    a_cmp_override: assert property (
        f_ovr[1] && !r_reg.f_dir[1] && !f_seg[1] |-> pf_oe[1] && pf_out[1] == cmp_out[1])
        else $error("comparator two output missing");

    a_vref_blocks: assert property (vref_drive |-> !pf_oe[5] && !f_din[5])
        else $error("reference pin not blocked");

    a_dir_readback: assert property (
        wr_stb && ofs == `GFG_OFS_PG_DIR |=> r_reg.g_dir == ($past(pwdata[7:0]) & `GFG_PG_MASK))
        else $error("direction register readback wrong");

    a_mclr_read: assert property (
        rd_setup && ofs == `GFG_OFS_PG_PIN |=> prdata[5] == $past(mclr_rd))
        else $error("master-clear bit read wrong");

    a_ccp_override: assert property (
        ccp_act[1] && !r_reg.g_dir[3] && !r_reg.od2[1] |-> pg_oe[3] && pg_out[3] == ccp_out[1])
        else $error("capture/compare four output missing");

    a_tx_force: assert property (
        serial_two_transmit_en && !r_reg.od1[`GFG_OD1_SER2] |-> pg_oe[1] && pg_out[1] == serial_two_transmit)
        else $error("serial transmit not on pin");

    a_open_drain: assert property (
        ccp_act[0] && !r_reg.g_dir[0] && r_reg.od2[0] |-> !pg_out[0] && pg_oe[0] == !ccp_out[0])
        else $error("open drain drives high");

    a_latch_write: assert property (
        wr_stb && ofs == `GFG_OFS_PF_PIN |=> r_reg.f_lat == ($past(pwdata[7:0]) & `GFG_PF_MASK))
        else $error("pin write missed latch");

endmodule
`default_nettype wire
